// *** hw/asf_top.v ***
// Arithmetic status and core status registers behind an AXI4-Lite slave
//
// Functional notes
// - Pointer one step: 00 dec, 01 inc, 1x hold
// - Pointer zero step: 00 dec, 01 inc, 1x hold
// - Overflow flag set on signed sign-flip overflow
// - Zero flag reflects result equal to zero
// - Nibble carry from bit three on adds
// - Carry from bit seven on adds
// - Subtract flags: set means no borrow
// - Subtract adds two's complement of operand
// - Rotates load carry with shifted-out bit
// - Core status holds global interrupt disable
// - Core status shows stack, sleep, timeout bits
// - Hardware-owned core bits ignore core status writes; only reset (to 1) and HWEV register writes set them
// - Pointer stepping never touches arithmetic flags
`include "asf_consts.vh"
module asf_top (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output reg         s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output reg         s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output reg         s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  output reg         irq_out,
  output reg         global_int_off_out
);
  reg  [7:0] arith_status_reg;
  reg  [7:0] core_status_reg_ctl;
  reg        stack_room_flag;
  reg        sleep_entered_flag;
  reg        watchdog_expired_flag;
  reg  [7:0] op_a;
  reg  [7:0] op_b;
  reg  [2:0] op_code;
  reg  [7:0] alu_result;
  reg  [7:0] indirect_ptr_zero;
  reg  [7:0] indirect_ptr_one;
  reg  [3:0] irq_stat;
  reg  [3:0] irq_mask;
  reg  [7:0] aw_addr;
  reg        aw_held;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  reg        w_held;
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_dc;
  wire       alu_z;
  wire       alu_ov;
  wire [7:0] ptr0_next;
  wire [7:0] ptr1_next;
  wire [7:0] core_view;
  wire [2:0] alu_op;
  wire [7:0] alu_a;
  wire [7:0] alu_b;
  wire       alu_arith;

  asf_alu u_alu (
    .op_in      (alu_op),
    .a_in       (alu_a),
    .b_in       (alu_b),
    .carry_in   (arith_status_reg[`ASF_BIT_C]),
    .result_out (alu_res),
    .c_out      (alu_c),
    .dc_out     (alu_dc),
    .z_out      (alu_z),
    .ov_out     (alu_ov),
    .arith_out  (alu_arith)
  );

  asf_ptr_step u_step0 (
    .sel_in  (arith_status_reg[5:4]),
    .ptr_in  (indirect_ptr_zero),
    .ptr_out (ptr0_next)
  );

  asf_ptr_step u_step1 (
    .sel_in  (arith_status_reg[7:6]),
    .ptr_in  (indirect_ptr_one),
    .ptr_out (ptr1_next)
  );

  // Hardware bits overlay the software-held control byte
  assign core_view = {core_status_reg_ctl[7:6], stack_room_flag,
                      core_status_reg_ctl[`ASF_CORE_GIE_OFF],
                      sleep_entered_flag, watchdog_expired_flag,
                      core_status_reg_ctl[1:0]};

  wire       do_write = (aw_held || s_axi_awvalid_in) && (w_held || s_axi_wvalid_in)
                        && !s_axi_bvalid_out;
  wire [7:0] wr_addr  = aw_held ? aw_addr : s_axi_awaddr_in;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_in;
  wire [3:0] wr_strb  = w_held ? w_strb : s_axi_wstrb_in;
  wire       wr_lo    = do_write && wr_strb[0];
  wire       do_read  = s_axi_arvalid_in && s_axi_arready_out;

  wire wr_arith  = wr_lo && (wr_addr == `ASF_ADDR_ARITH);
  wire wr_core   = wr_lo && (wr_addr == `ASF_ADDR_CORE);
  wire wr_op     = do_write && (wr_addr == `ASF_ADDR_OP);
  // Operands of an op write feed the ALU in the same edge
  assign alu_op = wr_op ? wr_data[18:16] : op_code;
  assign alu_a  = wr_op ? wr_data[7:0] : op_a;
  assign alu_b  = wr_op ? wr_data[15:8] : op_b;
  wire wr_ptr0   = wr_lo && (wr_addr == `ASF_ADDR_PTR0);
  wire wr_ptr1   = wr_lo && (wr_addr == `ASF_ADDR_PTR1);
  wire wr_access = wr_lo && (wr_addr == `ASF_ADDR_ACCESS);
  wire wr_hwev   = wr_lo && (wr_addr == `ASF_ADDR_HWEV);
  wire wr_istat  = wr_lo && (wr_addr == `ASF_ADDR_IRQ_STAT);
  wire wr_imask  = wr_lo && (wr_addr == `ASF_ADDR_IRQ_MASK);
  wire wr_known  = (wr_addr == `ASF_ADDR_ARITH) || (wr_addr == `ASF_ADDR_CORE) ||
                   (wr_addr == `ASF_ADDR_OP) || (wr_addr == `ASF_ADDR_RESULT) ||
                   (wr_addr == `ASF_ADDR_PTR0) || (wr_addr == `ASF_ADDR_PTR1) ||
                   (wr_addr == `ASF_ADDR_ACCESS) || (wr_addr == `ASF_ADDR_HWEV) ||
                   (wr_addr == `ASF_ADDR_IRQ_STAT) || (wr_addr == `ASF_ADDR_IRQ_MASK);

  // Write channel capture and response
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held           <= 1'b0;
      aw_addr           <= 8'h00;
      w_held            <= 1'b0;
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `ASF_RESP_OKAY;
    end else begin
      if (do_write) begin
        aw_held           <= 1'b0;
        w_held            <= 1'b0;
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out  <= 1'b0;
        s_axi_bvalid_out  <= 1'b1;
        s_axi_bresp_out   <= wr_known ? `ASF_RESP_OKAY : `ASF_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid_in && s_axi_awready_out) begin
          aw_held           <= 1'b1;
          aw_addr           <= s_axi_awaddr_in;
          s_axi_awready_out <= 1'b0;
        end
        if (s_axi_wvalid_in && s_axi_wready_out) begin
          w_held           <= 1'b1;
          w_data           <= s_axi_wdata_in;
          w_strb           <= s_axi_wstrb_in;
          s_axi_wready_out <= 1'b0;
        end
        if (s_axi_bvalid_out && s_axi_bready_in) begin
          s_axi_bvalid_out  <= 1'b0;
          s_axi_awready_out <= 1'b1;
          s_axi_wready_out  <= 1'b1;
        end
      end
    end
  end

  // Register state
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arith_status_reg      <= `ASF_ARITH_RESET;
      core_status_reg_ctl   <= 8'h00;
      stack_room_flag       <= 1'b1;
      sleep_entered_flag    <= 1'b1;
      watchdog_expired_flag <= 1'b1;
      op_a                  <= 8'h00;
      op_b                  <= 8'h00;
      op_code               <= 3'h0;
      alu_result            <= 8'h00;
      indirect_ptr_zero     <= 8'h00;
      indirect_ptr_one      <= 8'h00;
      irq_stat              <= 4'h0;
      irq_mask              <= 4'h0;
      irq_out               <= 1'b0;
      global_int_off_out    <= 1'b0;
    end else begin
      if (wr_arith) begin
        arith_status_reg <= wr_data[7:0];
      end else if (wr_op) begin
        alu_result <= alu_res;
        arith_status_reg[`ASF_BIT_C] <= alu_c;
        arith_status_reg[`ASF_BIT_Z] <= alu_z;
        if (alu_arith) begin
          arith_status_reg[`ASF_BIT_DC] <= alu_dc;
          arith_status_reg[`ASF_BIT_OV] <= alu_ov;
        end
      end
      if (wr_op) begin
        op_a <= wr_data[7:0];
        op_b <= wr_data[15:8];
        op_code <= wr_data[18:16];
      end
      if (wr_core) begin
        // Only the control bits are stored; hardware bits stay
        core_status_reg_ctl <= {wr_data[7:6], 1'b0, wr_data[4], 2'b00, wr_data[1:0]};
      end
      global_int_off_out <= core_status_reg_ctl[`ASF_CORE_GIE_OFF];
      // Pointer step after access; flags untouched
      if (wr_ptr0)
        indirect_ptr_zero <= wr_data[7:0];
      else if (wr_access && wr_data[0])
        indirect_ptr_zero <= ptr0_next;
      if (wr_ptr1)
        indirect_ptr_one <= wr_data[7:0];
      else if (wr_access && wr_data[1])
        indirect_ptr_one <= ptr1_next;
      if (wr_hwev) begin
        stack_room_flag       <= wr_data[0];
        sleep_entered_flag    <= wr_data[1];
        watchdog_expired_flag <= wr_data[2];
      end
      // Events: 0 zero, 1 carry, 2 overflow, 3 stack exhausted; set beats clear
      irq_stat <= (irq_stat & ~(wr_istat ? wr_data[3:0] : 4'h0)) |
                  {wr_hwev && !wr_data[0] && stack_room_flag,
                   wr_op && alu_ov && alu_arith,
                   wr_op && alu_c, wr_op && alu_z};
      if (wr_imask)
        irq_mask <= wr_data[3:0];
      irq_out <= |(irq_stat & irq_mask);
    end
  end

  // Read channel
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `ASF_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= `ASF_RESP_OKAY;
        case (s_axi_araddr_in)
          `ASF_ADDR_ARITH:    s_axi_rdata_out <= {24'h000000, arith_status_reg};
          `ASF_ADDR_CORE:     s_axi_rdata_out <= {24'h000000, core_view};
          `ASF_ADDR_OP:       s_axi_rdata_out <= {13'h0000, op_code, op_b, op_a};
          `ASF_ADDR_RESULT:   s_axi_rdata_out <= {24'h000000, alu_result};
          `ASF_ADDR_PTR0:     s_axi_rdata_out <= {24'h000000, indirect_ptr_zero};
          `ASF_ADDR_PTR1:     s_axi_rdata_out <= {24'h000000, indirect_ptr_one};
          `ASF_ADDR_ACCESS:   s_axi_rdata_out <= 32'h00000000;
          `ASF_ADDR_HWEV:     s_axi_rdata_out <= {29'h00000000, watchdog_expired_flag,
                                                  sleep_entered_flag, stack_room_flag};
          `ASF_ADDR_IRQ_STAT: s_axi_rdata_out <= {28'h0000000, irq_stat};
          `ASF_ADDR_IRQ_MASK: s_axi_rdata_out <= {28'h0000000, irq_mask};
          default: begin
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= `ASF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule

// *** pkg/asf_consts.vh ***
// Constants for the arithmetic status and core status block
`ifndef ASF_CONSTS_VH
`define ASF_CONSTS_VH
`define ASF_ADDR_ARITH      8'h00
// Core status sits at word index 06h; the bus byte address is four times that
`define ASF_IDX_CORE        8'h06
`define ASF_ADDR_CORE       8'h18
`define ASF_ADDR_OP         8'h08
`define ASF_ADDR_RESULT     8'h0C
`define ASF_ADDR_PTR0       8'h10
`define ASF_ADDR_PTR1       8'h14
`define ASF_ADDR_ACCESS     8'h28
`define ASF_ADDR_HWEV       8'h1C
`define ASF_ADDR_IRQ_STAT   8'h20
`define ASF_ADDR_IRQ_MASK   8'h24
`define ASF_ARITH_RESET     8'hF0
`define ASF_CORE_RESET      8'h20
`define ASF_BIT_C           0
`define ASF_BIT_DC          1
`define ASF_BIT_Z           2
`define ASF_BIT_OV          3
`define ASF_CORE_GIE_OFF    4
`define ASF_CORE_STACK      5
`define ASF_CORE_SLEEP      3
`define ASF_CORE_WDT        2
`define ASF_OP_ADD          3'h0
`define ASF_OP_SUB          3'h1
`define ASF_OP_AND          3'h2
`define ASF_OP_OR           3'h3
`define ASF_OP_XOR          3'h4
`define ASF_OP_RLC          3'h5
`define ASF_OP_RRC          3'h6
`define ASF_STEP_DEC        2'h0
`define ASF_STEP_INC        2'h1
`define ASF_RESP_OKAY       2'h0
`define ASF_RESP_SLVERR     2'h2
`endif

// *** hw/asf_alu.v ***
// Combinational 8-bit ALU with status flag generation
`include "asf_consts.vh"
module asf_alu (
  input  wire [2:0] op_in,
  input  wire [7:0] a_in,
  input  wire [7:0] b_in,
  input  wire       carry_in,
  output reg  [7:0] result_out,
  output reg        c_out,
  output reg        dc_out,
  output reg        z_out,
  output reg        ov_out,
  output reg        arith_out
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] b_eff;
  always @* begin
    sum        = 9'h000;
    nib        = 5'h00;
    b_eff      = b_in;
    result_out = 8'h00;
    c_out      = carry_in;
    dc_out     = 1'b0;
    ov_out     = 1'b0;
    arith_out  = 1'b0;
    case (op_in)
      `ASF_OP_ADD, `ASF_OP_SUB: begin
        // Subtract adds the inverse plus one; carry set means no borrow
        b_eff = (op_in == `ASF_OP_SUB) ? ~b_in : b_in;
        sum   = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, (op_in == `ASF_OP_SUB)};
        nib   = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (op_in == `ASF_OP_SUB)};
        result_out = sum[7:0];
        c_out      = sum[8];
        dc_out     = nib[4];
        ov_out     = (a_in[7] == b_eff[7]) && (sum[7] != a_in[7]);
        arith_out  = 1'b1;
      end
      `ASF_OP_AND: result_out = a_in & b_in;
      `ASF_OP_OR:  result_out = a_in | b_in;
      `ASF_OP_XOR: result_out = a_in ^ b_in;
      `ASF_OP_RLC: begin
        result_out = {a_in[6:0], carry_in};
        c_out      = a_in[7];
      end
      `ASF_OP_RRC: begin
        result_out = {carry_in, a_in[7:1]};
        c_out      = a_in[0];
      end
      default: result_out = a_in;
    endcase
    z_out = (result_out == 8'h00);
  end
endmodule

// *** hw/asf_ptr_step.v ***
// Post-access step of one indirect address pointer
`include "asf_consts.vh"
module asf_ptr_step (
  input  wire [1:0] sel_in,
  input  wire [7:0] ptr_in,
  output reg  [7:0] ptr_out
);
  always @* begin
    case (sel_in)
      `ASF_STEP_DEC: ptr_out = ptr_in - 8'h01;
      `ASF_STEP_INC: ptr_out = ptr_in + 8'h01;
      default:       ptr_out = ptr_in;
    endcase
  end
endmodule

// *** tb/asf_monitor.sv ***
// Port-level assertions for the status flag block
`include "asf_consts.vh"
module asf_monitor (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  s_axi_awaddr_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0]  s_axi_wstrb_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic        global_int_off_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_core_wr;
    s_wr_take ##0 (s_axi_awaddr_in == `ASF_ADDR_CORE && s_axi_wstrb_in[0]);
  endsequence
  property p_wr_answer;
    s_wr_take |=> s_axi_bvalid_out && !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_release;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out;
  endproperty
  a_b_release: assert property (p_b_release) else $error("write response not released");
  property p_rd_answer;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_upper;
    s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  property p_gie_set;
    s_core_wr ##0 s_axi_wdata_in[4] |=> ##1 global_int_off_out;
  endproperty
  a_gie_set: assert property (p_gie_set) else $error("interrupt disable not set");
  property p_gie_clr;
    s_core_wr ##0 !s_axi_wdata_in[4] |=> ##1 !global_int_off_out;
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("interrupt disable not cleared");
  property p_unmapped;
    s_wr_take ##0 (s_axi_awaddr_in == 8'h04) |=> s_axi_bresp_out == `ASF_RESP_SLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped write accepted");
endmodule
bind asf_top asf_monitor u_mon (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .global_int_off_out);

// *** tb/asf_top_bench.sv ***
// Self-checking bench for the status flag block
`include "asf_consts.vh"
module asf_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, rst_n_in, irq_out, global_int_off_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, m_ar;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0]  s_axi_wstrb_in;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, bq[$];
  logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic        s_axi_rvalid_out, s_axi_rready_in, c, dc, ov;
  logic [33:0] rq[$];
  int          err_count, compares;
  asf_top DUT (.clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
    .s_axi_rready_in, .irq_out, .global_int_off_out);
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    bit ap, wp;
    ap = 1;
    wp = 1;
    bq.push_back(er);
    s_axi_awaddr_in <= ad;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    while (ap || wp) begin
      @(posedge clk_in);
      if (ap && s_axi_awready_out) begin
        ap = 0;
        s_axi_awvalid_in <= 1'b0;
      end
      if (wp && s_axi_wready_out) begin
        wp = 0;
        s_axi_wvalid_in <= 1'b0;
      end
    end
    do @(posedge clk_in); while (!s_axi_bvalid_out);
    // One stall cycle so the response must stand
    s_axi_bready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] v, input logic [1:0] rs = 2'h0);
    rq.push_back({rs, 24'h0, v});
    s_axi_araddr_in <= ad;
    s_axi_arvalid_in <= 1'b1;
    do @(posedge clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    do @(posedge clk_in); while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic alu(input logic [2:0] o, input logic [7:0] x, input logic [7:0] y);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] yy, r;
    yy = o[0] ? ~y : y;
    s = {1'b0, x} + {1'b0, yy} + {8'h0, o[0]};
    h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, o[0]};
    case (o)
      `ASF_OP_AND: r = x & y;
      `ASF_OP_OR:  r = x | y;
      `ASF_OP_XOR: r = x ^ y;
      `ASF_OP_RLC: begin
        r = {x[6:0], c};
        c = x[7];
      end
      `ASF_OP_RRC: begin
        r = {c, x[7:1]};
        c = x[0];
      end
      default: begin
        r = s[7:0];
        c = s[8];
        dc = h[4];
        ov = (x[7] == yy[7]) && (r[7] != x[7]);
      end
    endcase
    m_ar = {m_ar[7:4], ov, r == 8'h0, dc, c};
    wr(`ASF_ADDR_OP, {13'h0, o, y, x});
    rd(`ASF_ADDR_RESULT, r);
    rd(`ASF_ADDR_ARITH, m_ar);
  endtask
  always @(posedge clk_in) begin
    if (s_axi_rvalid_out && s_axi_rready_in) chk({s_axi_rresp_out, s_axi_rdata_out}, rq.pop_front());
    if (s_axi_bvalid_out && s_axi_bready_in) chk({32'h0, s_axi_bresp_out}, {32'h0, bq.pop_front()});
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    #400000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_n_in, s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in} = '0;
    {s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'hF;
    void'($urandom(83082));
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rd(`ASF_ADDR_ARITH, `ASF_ARITH_RESET);
    rd(`ASF_ADDR_CORE, 8'h2C);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      wr(`ASF_ADDR_PTR0, 32'h01);
      wr(`ASF_ADDR_PTR1, 32'hFF);
      wr(`ASF_ADDR_ARITH, {24'h0, s[1:0], s[1:0], 4'h5});
      wr(`ASF_ADDR_ACCESS, 32'h3);
      rd(`ASF_ADDR_PTR0, s == 0 ? 8'h00 : s == 1 ? 8'h02 : 8'h01);
      rd(`ASF_ADDR_PTR1, s == 0 ? 8'hFE : s == 1 ? 8'h00 : 8'hFF);
      rd(`ASF_ADDR_ARITH, {s[1:0], s[1:0], 4'h5});
    end
    $display("pointer step test done");
    m_ar = 8'($urandom);
    {ov, dc, c} = {m_ar[3], m_ar[1:0]};
    wr(`ASF_ADDR_ARITH, {24'h0, m_ar});
    rd(`ASF_ADDR_ARITH, m_ar);
    alu(`ASF_OP_ADD, 8'hFF, 8'h01);
    alu(`ASF_OP_ADD, 8'h7F, 8'h01);
    alu(`ASF_OP_SUB, 8'h05, 8'h05);
    alu(`ASF_OP_SUB, 8'h00, 8'h01);
    alu(`ASF_OP_SUB, 8'h80, 8'h01);
    for (int i = 0; i < 28; i++)
      alu(i < 7 ? 3'(i) : 3'($urandom_range(6, 0)), 8'($urandom), 8'($urandom));
    $display("flag test done");
    wr(`ASF_ADDR_HWEV, 32'h0);
    rd(`ASF_ADDR_CORE, 8'h00);
    wr(`ASF_ADDR_CORE, 32'hFF);
    rd(`ASF_ADDR_CORE, 8'hD3);
    chk(global_int_off_out, 1);
    wr(`ASF_ADDR_HWEV, 32'h7);
    rd(`ASF_ADDR_CORE, 8'hFF);
    wr(`ASF_ADDR_CORE, 32'h0);
    rd(`ASF_ADDR_CORE, 8'h2C);
    chk(global_int_off_out, 0);
    s_axi_wstrb_in <= 4'h0;
    wr(`ASF_ADDR_CORE, 32'hFF);
    s_axi_wstrb_in <= 4'hF;
    rd(`ASF_ADDR_CORE, 8'h2C);
    $display("core status test done");
    wr(`ASF_ADDR_IRQ_STAT, 32'hF);
    wr(`ASF_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 0);
    alu(`ASF_OP_AND, 8'h0F, 8'hF0);
    chk(irq_out, 1);
    wr(`ASF_ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 0);
    wr(`ASF_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 1);
    wr(`ASF_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_in);
    chk(irq_out, 0);
    $display("interrupt test done");
    wr(8'h04, 32'hFF, `ASF_RESP_SLVERR);
    rd(8'h04, 8'h00, `ASF_RESP_SLVERR);
    repeat (2) @(posedge clk_in);
    $display("unmapped test done");
    stop_test();
  end
endmodule
